// ### hw/ldm_pkg.sv
// constants, pin bundle and state encodings of the short-range modem block
// assumes a 200 MHz core clock; every pin input is asynchronous to it
package ldm_pkg;

  // ----------------------------------------------------------------
  // clock and burst line timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned BURST_BPS  = 256_000;
  // longest bit time: rounded down to whole cycles
  localparam int unsigned BIT_CYC    = CLK_HZ / BURST_BPS;
  localparam logic [9:0]  BIT_LAST   = 10'(BIT_CYC - 1);
  localparam logic [9:0]  BIT_HALF   = 10'(BIT_CYC / 2);
  localparam logic [3:0]  DATA_FIRST = 4'h1;
  localparam logic [3:0]  DATA_LAST  = 4'h8;
  localparam logic [3:0]  SIG_A_IDX  = 4'h9;
  localparam logic [3:0]  SIG_B_IDX  = 4'hA;
  localparam logic [3:0]  GAP_BITS   = 4'h4;

  // ----------------------------------------------------------------
  // synchronous word format
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAG_SYNC  = 8'h7E;
  localparam logic [7:0]  FLAG_BREAK = 8'hFE;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;
  localparam logic [3:0]  FLAG_EVERY = 4'hF;
  localparam logic [7:0]  LOSS_BITS  = 8'hC8;
  localparam logic [3:0]  LEN8       = 4'h8;
  localparam logic [3:0]  LEN9       = 4'h9;

  // ----------------------------------------------------------------
  // asynchronous side
  // ----------------------------------------------------------------
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned RATE_BASE  = 300;
  localparam logic [3:0]  TICK_MID   = 4'h7;
  localparam logic [3:0]  TICK_LAST  = 4'hF;
  localparam int unsigned WORD_W     = 9;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef logic [WORD_W-1:0] word_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00, B_GAP = 2'b01, B_TX = 2'b11, B_RX = 2'b10
  } burst_st_t;

  typedef enum logic [1:0] {
    U_IDLE = 2'b00, U_START = 2'b01, U_DATA = 2'b11, U_STOP = 2'b10
  } uart_st_t;

  typedef struct packed {
    logic       master;
    logic       fsync;
    logic       line_rx;
    logic       rts;
    logic       txd;
    logic [2:0] rate;
    logic       ext_sel;
    logic       ext_rate;
    logic       dclk;
    logic       cm;
    logic       oe;
    logic       ie;
    logic       sdata;
    logic       stop2;
    logic       len9;
    logic       cres_n;
  } pins_t;

  // 16x tick divider, minus one, for 300 * 2**sel bit/s
  function automatic logic [15:0] rate_div(input logic [2:0] sel);
    rate_div = 16'(CLK_HZ / (OVERSAMPLE * (RATE_BASE << sel)) - 1);
  endfunction

endpackage

// ### hw/async_sync_burst_modem_link.sv
// short-range modem: async/sync converter plus ping-pong burst transceiver
// assumes every input pin is asynchronous to clk_i; line pins are logic levels
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// word fifo between async receiver and sync transmitter
// ------------------------------------------------------------------
module ldm_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } fst_t;

  fst_t st_ff;
  fst_t nxt_st;
  logic full;

  assign full        = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign in_ready_o  = !full && !flush_i;
  assign out_valid_o = (st_ff.wp != st_ff.rp) && !flush_i;
  assign out_data_o  = st_ff.mem[st_ff.rp[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (flush_i) begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
    end else begin
      if (in_valid_i && in_ready_o) begin
        nxt_st.mem[st_ff.wp[AW-1:0]] = in_data_i;
        nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (out_valid_o && out_ready_i) begin
        nxt_st.rp = st_ff.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // ldm_fifo

// ------------------------------------------------------------------
// top: one modem end, master or slave by strap
// ------------------------------------------------------------------
module async_sync_burst_modem_link (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic is_master_i,
  input  wire logic frame_sync_in_i,
  input  wire logic line_receive_in_i,
  output logic      line_drive_pos_o,
  output logic      line_drive_neg_o,
  output logic      signal_bit_out_a_o,
  output logic      signal_bit_out_b_o,
  input  wire logic rts_i,
  output logic      cts_o,
  output logic      carrier_detect_o,
  input  wire logic txd_i,
  output logic      rxd_o,
  input  wire logic rate_select_0_i,
  input  wire logic rate_select_1_i,
  input  wire logic rate_select_2_i,
  input  wire logic ext_rate_sel_i,
  input  wire logic ext_rate_clk_i,
  input  wire logic sync_data_clock_i,
  input  wire logic clock_mode_sel_i,
  input  wire logic sync_out_enable_i,
  input  wire logic sync_in_enable_i,
  input  wire logic sync_receive_in_i,
  output logic      sync_send_o,
  input  wire logic stop_count_sel_i,
  input  wire logic word_length_sel_i,
  input  wire logic converter_reset_n_i,
  output logic      tx_status_o,
  output logic      rx_status_o
);
  import ldm_pkg::*;

  typedef struct packed {
    pins_t      s1;
    pins_t      s2;
    logic       fs_d;
    logic       dck_d;
    logic       erc_d;
    logic       lrx_d;
    burst_st_t  bst;
    logic [9:0] bcyc;
    logic [3:0] bidx;
    logic       rx_on;
    logic       sig_a;
    logic       sig_b;
    logic       pos;
    logic       neg;
    logic [15:0] rdiv;
    uart_st_t   ust;
    logic [3:0] utk;
    logic [3:0] ubit;
    word_t      udat;
    logic       brk;
    logic       pv;
    word_t      tw;
    logic [3:0] tcnt;
    logic [2:0] tones;
    logic       tstuff;
    logic [3:0] fcnt;
    logic       sbit;
    logic [7:0] hist;
    word_t      rw;
    logic [3:0] rcnt;
    logic [2:0] rones;
    logic [7:0] loss;
    logic       insync;
    logic       rbrk;
    logic       rv;
    word_t      rword;
    uart_st_t   vst;
    logic [3:0] vtk;
    logic [3:0] vbit;
    word_t      vsh;
    logic       rxd;
    logic       cts;
    logic       cd;
  } st_t;

  st_t   st_ff;
  st_t   nxt_st;
  pins_t pins;
  logic  fs_rise, dck_rise, dck_fall, erc_rise, tick, cres;
  logic  tx_slot, rx_slot, tx_stb, rx_stb, rx_bit, sa_tx, sb_tx;
  logic  g_stuff, g_load, g_dat, g_bit;
  word_t g_word;
  logic  [3:0] wlen;
  logic  f_iv, f_ir, f_ov, f_pop;
  word_t f_od;
  logic  [7:0] h;

  assign pins = '{master: is_master_i, fsync: frame_sync_in_i,
                  line_rx: line_receive_in_i, rts: rts_i, txd: txd_i,
                  rate: {rate_select_2_i, rate_select_1_i, rate_select_0_i},
                  ext_sel: ext_rate_sel_i, ext_rate: ext_rate_clk_i,
                  dclk: sync_data_clock_i, cm: clock_mode_sel_i,
                  oe: sync_out_enable_i, ie: sync_in_enable_i,
                  sdata: sync_receive_in_i, stop2: stop_count_sel_i,
                  len9: word_length_sel_i, cres_n: converter_reset_n_i};

  // ----------------------------------------------------------------
  // edges from the second sync stage; timing strobes also from the rate divider and burst counters
  // ----------------------------------------------------------------
  assign fs_rise  = st_ff.s2.fsync & ~st_ff.fs_d;
  assign dck_rise = st_ff.s2.dclk & ~st_ff.dck_d;
  assign dck_fall = ~st_ff.s2.dclk & st_ff.dck_d;
  assign erc_rise = st_ff.s2.ext_rate & ~st_ff.erc_d;
  assign cres     = ~st_ff.s2.cres_n;
  assign wlen     = st_ff.s2.len9 ? LEN9 : LEN8;
  // external rate clock is taken as 16x the bit rate
  assign tick     = st_ff.s2.ext_sel ? erc_rise : (st_ff.rdiv == 16'h0000);

  assign tx_slot = (st_ff.bst == B_TX) && (st_ff.bcyc == 10'h000)
                 && (st_ff.bidx >= DATA_FIRST) && (st_ff.bidx <= DATA_LAST);
  assign rx_slot = (st_ff.bst == B_RX) && st_ff.rx_on && (st_ff.bcyc == BIT_LAST)
                 && (st_ff.bidx >= DATA_FIRST) && (st_ff.bidx <= DATA_LAST);
  assign tx_stb  = st_ff.s2.oe & (st_ff.s2.cm ? dck_rise : tx_slot);
  assign rx_stb  = st_ff.s2.ie & (st_ff.s2.cm ? dck_fall : rx_slot);
  assign rx_bit  = st_ff.s2.cm ? st_ff.s2.sdata : st_ff.s2.line_rx;

  // handshake loops: each end drives its own rts on one channel, echoes the other
  assign sa_tx = st_ff.s2.master ? st_ff.s2.rts : st_ff.sig_a;
  assign sb_tx = st_ff.s2.master ? st_ff.sig_b : st_ff.s2.rts;

  // ----------------------------------------------------------------
  // sync bit generator, a pure function of state
  // ----------------------------------------------------------------
  assign g_stuff = st_ff.tstuff && (st_ff.tones == STUFF_RUN);
  assign g_load  = (st_ff.tcnt == 4'h0);
  assign g_dat   = !st_ff.brk && (st_ff.fcnt != FLAG_EVERY) && f_ov;
  assign g_word  = st_ff.brk ? {1'b0, FLAG_BREAK}
                 : g_dat ? f_od : {1'b0, FLAG_SYNC};
  assign g_bit   = g_stuff ? 1'b0 : (g_load ? g_word[0] : st_ff.tw[0]);
  assign f_pop   = tx_stb && !g_stuff && g_load && g_dat;
  assign f_iv    = st_ff.pv;
  assign h       = {rx_bit, st_ff.hist[7:1]};

  ldm_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (cres),
    .in_valid_i  (f_iv),
    .in_ready_o  (f_ir),
    .in_data_i   (st_ff.udat),
    .out_valid_o (f_ov),
    .out_ready_i (f_pop),
    .out_data_o  (f_od)
  );

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.s1    = pins;
    nxt_st.s2    = st_ff.s1;
    nxt_st.fs_d  = st_ff.s2.fsync;
    nxt_st.dck_d = st_ff.s2.dclk;
    nxt_st.erc_d = st_ff.s2.ext_rate;
    nxt_st.lrx_d = st_ff.s2.line_rx;
    nxt_st.rdiv  = (st_ff.rdiv == 16'h0000) ? rate_div(st_ff.s2.rate)
                                            : st_ff.rdiv - 16'h0001;

    // --------------------------------------------------------------
    // burst transceiver
    // --------------------------------------------------------------
    case (st_ff.bst)
      B_IDLE: begin
        if (!st_ff.s2.master) begin
          nxt_st.bst = B_RX;
        end
      end
      B_TX: begin
        nxt_st.bcyc = st_ff.bcyc + 10'h001;
        if (st_ff.bcyc == 10'h000) begin
          case (st_ff.bidx)
            4'h0:      nxt_st.pos = 1'b1;             // burst marker
            SIG_A_IDX: nxt_st.pos = sa_tx;
            SIG_B_IDX: nxt_st.pos = sb_tx;
            default:   nxt_st.pos = st_ff.s2.oe ? g_bit : 1'b1;
          endcase
          nxt_st.neg = ~nxt_st.pos;
        end
        if (st_ff.bcyc == BIT_LAST) begin
          nxt_st.bcyc = 10'h000;
          nxt_st.bidx = st_ff.bidx + 4'h1;
          if (st_ff.bidx == SIG_B_IDX) begin
            nxt_st.bst   = B_RX;
            nxt_st.rx_on = 1'b0;
            nxt_st.pos   = 1'b0;
            nxt_st.neg   = 1'b0;
          end
        end
      end
      B_RX: begin
        if (!st_ff.rx_on) begin
          if (st_ff.s2.line_rx && !st_ff.lrx_d) begin
            nxt_st.rx_on = 1'b1;
            nxt_st.bcyc  = BIT_HALF;
            nxt_st.bidx  = 4'h0;
          end
        end else begin
          nxt_st.bcyc = st_ff.bcyc + 10'h001;
          if (st_ff.bcyc == BIT_LAST) begin
            nxt_st.bcyc = 10'h000;
            nxt_st.bidx = st_ff.bidx + 4'h1;
            if (st_ff.bidx == SIG_A_IDX) begin
              nxt_st.sig_a = st_ff.s2.line_rx;
            end
            if (st_ff.bidx == SIG_B_IDX) begin
              nxt_st.sig_b = st_ff.s2.line_rx;
              nxt_st.rx_on = 1'b0;
              nxt_st.bidx  = 4'h0;
              nxt_st.bst   = st_ff.s2.master ? B_IDLE : B_GAP;
            end
          end
        end
      end
      B_GAP: begin
        nxt_st.bcyc = st_ff.bcyc + 10'h001;
        if (st_ff.bcyc == BIT_LAST) begin
          nxt_st.bcyc = 10'h000;
          nxt_st.bidx = st_ff.bidx + 4'h1;
          if (st_ff.bidx == GAP_BITS) begin
            nxt_st.bst  = B_TX;
            nxt_st.bidx = 4'h0;
          end
        end
      end
      default: nxt_st.bst = B_IDLE;
    endcase
    // a frame sync always restarts the master burst, even mid-listen
    if (st_ff.s2.master && fs_rise) begin
      nxt_st.bst  = B_TX;
      nxt_st.bcyc = 10'h000;
      nxt_st.bidx = 4'h0;
    end

    // --------------------------------------------------------------
    // async receiver from terminal
    // --------------------------------------------------------------
    if (st_ff.pv && f_ir) begin
      nxt_st.pv = 1'b0;
    end
    if (tick) begin
      nxt_st.utk = st_ff.utk + 4'h1;
      case (st_ff.ust)
        U_IDLE: begin
          nxt_st.utk = 4'h0;
          // a pending word holds off the next start bit: fifo back-pressure
          if (!st_ff.pv && !st_ff.s2.txd) begin
            nxt_st.ust = U_START;
          end
        end
        U_START: begin
          if (st_ff.utk == TICK_MID) begin
            nxt_st.utk  = 4'h0;
            nxt_st.ubit = 4'h0;
            nxt_st.ust  = st_ff.s2.txd ? U_IDLE : U_DATA;
          end
        end
        U_DATA: begin
          if (st_ff.utk == TICK_LAST) begin
            nxt_st.udat = st_ff.s2.len9 ? {st_ff.s2.txd, st_ff.udat[8:1]}
                                        : {1'b0, st_ff.s2.txd, st_ff.udat[7:1]};
            nxt_st.ubit = st_ff.ubit + 4'h1;
            if (st_ff.ubit == wlen - 4'h1) begin
              nxt_st.ust = U_STOP;
            end
          end
        end
        U_STOP: begin
          if (st_ff.utk == TICK_LAST) begin
            nxt_st.ust = U_IDLE;
            if (st_ff.s2.txd) begin
              nxt_st.pv  = 1'b1;
              nxt_st.brk = 1'b0;
            end else if (st_ff.udat == '0) begin
              nxt_st.brk = 1'b1;
            end
          end
        end
        default: nxt_st.ust = U_IDLE;
      endcase
    end

    // --------------------------------------------------------------
    // sync transmitter: flags, data and zero insertion
    // --------------------------------------------------------------
    if (tx_stb) begin
      nxt_st.sbit = g_bit;
      if (g_stuff) begin
        nxt_st.tones = 3'h0;
      end else if (g_load) begin
        nxt_st.tw     = g_word >> 1;
        nxt_st.tcnt   = (g_dat ? wlen : LEN8) - 4'h1;
        nxt_st.tstuff = g_dat;
        nxt_st.fcnt   = g_dat ? st_ff.fcnt + 4'h1 : 4'h0;
        nxt_st.tones  = {2'b00, g_dat & g_word[0]};
      end else begin
        nxt_st.tw    = st_ff.tw >> 1;
        nxt_st.tcnt  = st_ff.tcnt - 4'h1;
        nxt_st.tones = (st_ff.tstuff && st_ff.tw[0]) ? st_ff.tones + 3'h1 : 3'h0;
      end
    end

    // --------------------------------------------------------------
    // async transmitter toward terminal (consumes before a new set)
    // --------------------------------------------------------------
    if (tick) begin
      nxt_st.vtk = st_ff.vtk + 4'h1;
      case (st_ff.vst)
        U_IDLE: begin
          nxt_st.vtk = 4'h0;
          nxt_st.rxd = !st_ff.rbrk;
          if (!st_ff.rbrk && st_ff.rv) begin
            nxt_st.rv  = 1'b0;
            nxt_st.vsh = st_ff.rword;
            nxt_st.rxd = 1'b0;
            nxt_st.vst = U_START;
          end
        end
        U_START: begin
          if (st_ff.vtk == TICK_LAST) begin
            nxt_st.rxd  = st_ff.vsh[0];
            nxt_st.vsh  = st_ff.vsh >> 1;
            nxt_st.vbit = 4'h0;
            nxt_st.vst  = U_DATA;
          end
        end
        U_DATA: begin
          if (st_ff.vtk == TICK_LAST) begin
            nxt_st.vbit = st_ff.vbit + 4'h1;
            nxt_st.rxd  = st_ff.vsh[0];
            nxt_st.vsh  = st_ff.vsh >> 1;
            if (st_ff.vbit == wlen - 4'h1) begin
              nxt_st.rxd  = 1'b1;
              nxt_st.vbit = 4'h0;
              nxt_st.vst  = U_STOP;
            end
          end
        end
        U_STOP: begin
          if (st_ff.vtk == TICK_LAST) begin
            nxt_st.vbit = st_ff.vbit + 4'h1;
            if (!st_ff.s2.stop2 || st_ff.vbit != 4'h0) begin
              nxt_st.vst = U_IDLE;
            end
          end
        end
        default: nxt_st.vst = U_IDLE;
      endcase
    end

    // --------------------------------------------------------------
    // sync receiver: flag hunt, zero deletion, word assembly
    // --------------------------------------------------------------
    if (rx_stb) begin
      nxt_st.hist = h;
      nxt_st.loss = (st_ff.loss == LOSS_BITS) ? st_ff.loss : st_ff.loss + 8'h01;
      if (st_ff.loss == LOSS_BITS) begin
        nxt_st.insync = 1'b0;
      end
      if (h == FLAG_SYNC) begin
        nxt_st.insync = 1'b1;
        nxt_st.loss   = 8'h00;
        nxt_st.rbrk   = 1'b0;
        nxt_st.rcnt   = 4'h0;
        nxt_st.rones  = 3'h0;
      end else if (h == FLAG_BREAK) begin
        nxt_st.rbrk  = 1'b1;
        nxt_st.rcnt  = 4'h0;
        nxt_st.rones = 3'h0;
      end else if (st_ff.rones == STUFF_RUN && !rx_bit) begin
        nxt_st.rones = 3'h0;
      end else begin
        nxt_st.rw = st_ff.s2.len9 ? {rx_bit, st_ff.rw[8:1]}
                                  : {1'b0, rx_bit, st_ff.rw[7:1]};
        nxt_st.rcnt  = st_ff.rcnt + 4'h1;
        nxt_st.rones = !rx_bit ? 3'h0
                     : (st_ff.rones == STUFF_RUN) ? st_ff.rones : st_ff.rones + 3'h1;
        if (st_ff.rcnt == wlen - 4'h1) begin
          nxt_st.rcnt  = 4'h0;
          nxt_st.rword = nxt_st.rw;
          nxt_st.rv    = 1'b1;
          nxt_st.rbrk  = 1'b0;
        end
      end
    end

    // --------------------------------------------------------------
    // handshake and status
    // --------------------------------------------------------------
    // cts follows the echo bit it is registered with, so it never outlives a dropped echo
    nxt_st.cts = st_ff.insync && (st_ff.s2.master ? nxt_st.sig_a : nxt_st.sig_b);
    nxt_st.cd  = st_ff.insync && !nxt_st.rxd;
    if (cres) begin
      nxt_st.ust = U_IDLE;
      nxt_st.pv  = 1'b0;
      nxt_st.brk = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign line_drive_pos_o   = st_ff.pos;
  assign line_drive_neg_o   = st_ff.neg;
  assign signal_bit_out_a_o = st_ff.sig_a;
  assign signal_bit_out_b_o = st_ff.sig_b;
  assign cts_o              = st_ff.cts;
  assign carrier_detect_o   = st_ff.cd;
  assign rxd_o              = st_ff.rxd;
  assign sync_send_o        = st_ff.sbit;
  assign tx_status_o        = st_ff.brk;
  assign rx_status_o        = st_ff.rbrk;
endmodule // async_sync_burst_modem_link

`default_nettype wire

// ### verification/ldm_terminal.sv
// terminal model: sends framed characters, captures framed ones
// assumes a 16x rate clock that gives BIT_T core cycles per bit
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// terminal
// ------------------------------------------------------------------
module ldm_terminal #(
  parameter int BIT_T = 128
) (
  input  wire logic clk_i,
  input  wire logic rxd_i,
  output var  logic txd_o
);
  initial txd_o = 1'b1;
  // a low stop bit over zero data is a break; the line is then left low
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      txd_o = f[i];
      repeat (BIT_T - 1) @(negedge clk_i);
    end
  endtask
  // bounded wait: a dead link must not hang the bench
  task automatic grab(output logic [7:0] d, output logic ok);
    int n;
    d = 8'h00;
    for (n = 0; n < 60000 && rxd_i !== 1'b0; n++) @(negedge clk_i);
    repeat (BIT_T / 2) @(negedge clk_i);
    ok = (n < 60000) && (rxd_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_T) @(negedge clk_i);
      d[i] = rxd_i;
    end
  endtask
endmodule // ldm_terminal
`default_nettype wire

// ### verification/ldm_checker.sv
// port assertions for one modem end
// assumes it is bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// checker
// ------------------------------------------------------------------
module ldm_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic is_master_i,
  input wire logic frame_sync_in_i,
  input wire logic line_drive_pos_o,
  input wire logic line_drive_neg_o,
  input wire logic signal_bit_out_a_o,
  input wire logic signal_bit_out_b_o,
  input wire logic cts_o,
  input wire logic carrier_detect_o,
  input wire logic rxd_o,
  input wire logic converter_reset_n_i,
  input wire logic tx_status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_line_exclusive: assert property (
    !(line_drive_pos_o && line_drive_neg_o)) else $error("both line drives high");
  a_pos_hold: assert property (
    $changed(line_drive_pos_o) |=> $stable(line_drive_pos_o) [*8]) else $error("pos bit short");
  a_neg_hold: assert property (
    $changed(line_drive_neg_o) |=> $stable(line_drive_neg_o) [*8]) else $error("neg bit short");
  a_burst_start: assert property (
    is_master_i && $rose(frame_sync_in_i) && !line_drive_pos_o && !line_drive_neg_o
    |-> ##[1:5] line_drive_pos_o) else $error("burst did not start");
  a_cd_from_rxd: assert property (
    carrier_detect_o |-> !rxd_o) else $error("carrier with rxd high");
  a_conv_reset: assert property (
    (!converter_reset_n_i) [*4] |-> !tx_status_o) else $error("status set in reset");
  a_cts_master: assert property (
    is_master_i && cts_o |-> signal_bit_out_a_o) else $error("master cts without echo");
  a_cts_slave: assert property (
    !is_master_i && cts_o |-> signal_bit_out_b_o) else $error("slave cts without echo");
endmodule // ldm_checker
bind async_sync_burst_modem_link ldm_checker ldm_checker_i (.*);
`default_nettype wire

// ### verification/async_sync_burst_modem_link_tb.sv
// bench: master and slave ends joined by their line pins
// assumes a 16x rate clock of 25 MHz, so one async bit is 128 cycles
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// bench
// ------------------------------------------------------------------
module async_sync_burst_modem_link_tb;
  import ldm_pkg::*;
  localparam int BT = 781;
  logic       clk, reset_n, ext_clk, fsync, ext_sel, dclk, mode, oe, ie, sdin, stop2, len9;
  logic [2:0] rsel;
  logic [1:0] pos, neg, sig_a, sig_b, cts, cd, txd, rxd, snd, txs, rxs, rts, crst_n;
  logic [7:0] got;
  logic       ok;
  int         err_total, check_count, t0, t1;
  for (genvar k = 0; k < 2; k++) begin : g
    ldm_terminal ldm_terminal_i (.clk_i(clk), .rxd_i(rxd[k]), .txd_o(txd[k]));
    async_sync_burst_modem_link async_sync_burst_modem_link_i (
      .clk_i(clk), .reset_n_i(reset_n), .is_master_i(1'(k == 0)),
      .frame_sync_in_i(fsync & 1'(k == 0)), .line_receive_in_i(pos[1-k]),
      .line_drive_pos_o(pos[k]), .line_drive_neg_o(neg[k]),
      .signal_bit_out_a_o(sig_a[k]), .signal_bit_out_b_o(sig_b[k]),
      .rts_i(rts[k]), .cts_o(cts[k]), .carrier_detect_o(cd[k]),
      .txd_i(txd[k]), .rxd_o(rxd[k]), .rate_select_0_i(rsel[0]),
      .rate_select_1_i(rsel[1]), .rate_select_2_i(rsel[2]), .ext_rate_sel_i(ext_sel),
      .ext_rate_clk_i(ext_clk), .sync_data_clock_i(dclk), .clock_mode_sel_i(mode),
      .sync_out_enable_i(oe), .sync_in_enable_i(ie), .sync_receive_in_i(sdin),
      .sync_send_o(snd[k]), .stop_count_sel_i(stop2), .word_length_sel_i(len9),
      .converter_reset_n_i(crst_n[k]), .tx_status_o(txs[k]), .rx_status_o(rxs[k]));
  end
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    ext_clk = 1'b0;
    #2.5;
    forever #20 ext_clk = ~ext_clk;
  end
  // frame period leaves room for both bursts and the slave gap
  initial begin
    fsync = 1'b0;
    wait (reset_n === 1'b1);
    forever begin
      @(negedge clk) fsync = 1'b1;
      repeat (10) @(negedge clk);
      fsync = 1'b0;
      repeat (21490) @(negedge clk);
    end
  end
  initial begin
    repeat (70000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    // burst-timed sync bits, both enables on, external 16x rate clock, two stop bits
    {reset_n, ext_sel, dclk, mode, oe, ie, sdin, stop2, len9} = 9'h09A;
    err_total = 0;
    check_count = 0;
    rsel = 3'h7;
    rts = 2'h3;
    crst_n = 2'h3;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check_val("line idle", 8'h00, {4'h0, pos, neg});
    fork
      g[0].ldm_terminal_i.send(8'hA5, 1'b1);
    join_none
    for (t0 = 0; t0 < 25000 && pos[0] !== 1'b1; t0++) @(negedge clk);
    check_val("marker", 8'h01, {7'h00, pos[0]});
    repeat (9 * BT + BT / 2) @(negedge clk);
    check_val("sig a slot", 8'h01, {7'h00, pos[0]});
    check_val("slave quiet", 8'h00, {7'h00, pos[1]});
    for (t1 = 0; t1 < 8 * BT && pos[1] !== 1'b1; t1++) @(negedge clk);
    t1 = t1 + 9 * BT + BT / 2;
    check_val("slave after gap", 8'h01, {7'h00, t1 > 11 * BT && t1 < 17 * BT});
    check_val("slave sig a", 8'h01, {7'h00, sig_a[1]});
    repeat (12 * BT) @(negedge clk);
    check_val("master echo", 8'h03, {6'h00, sig_b[0], sig_a[0]});
    g[1].ldm_terminal_i.grab(got, ok);
    check_val("char start", 8'h01, {7'h00, ok});
    check_val("char data", 8'hA5, got);
    // master async output idles high, so its inverted carrier reads low
    check_val("cd and cts", 8'h01, {6'h00, cd[0], cts[0]});
    check_val("no line break", 8'h00, {6'h00, rxs});
    g[0].ldm_terminal_i.send(8'h00, 1'b0);
    repeat (20) @(negedge clk);
    check_val("tx break", 8'h01, {7'h00, txs[0]});
    for (t0 = 0; t0 < 25000 && rxs[1] !== 1'b1; t0++) @(negedge clk);
    repeat (20) @(negedge clk);
    check_val("line break", 8'h03, {6'h00, rxs[1], cd[1]});
    crst_n[0] = 1'b0;
    repeat (8) @(negedge clk);
    check_val("tx status", 8'h00, {7'h00, txs[0]});
    crst_n[0] = 1'b1;
    print_verdict();
  end
endmodule // async_sync_burst_modem_link_tb
`default_nettype wire
